// file: swf_forward.sv
// receive forwarding filter of a two-port switch with apb registers
// assumes frame descriptors arrive as one-cycle pulses at frame start
// Summary of operation
// - after reset no filter applies and no unknown option is set, so all frames drop
// - one frame may go to the other port and the host together
// - sixteen destination filter entries are compared with every frame
// - a matching entry with its host flag set sends the frame deliver_flag_a
// - an entry applies to a port only when that port's apply flag is set
// - mask bits at zero exclude address bits from the comparison
// - unmatched frames drop unless the per-port unknown option is set
// - bad crc, phy error, runt and jabber frames drop and are counted
// - each port has a high and a low priority receive queue
// - queues reset to 12 kB low and 8 kB high, sizes writable
// - each port has fifteen 16-bit statistics counters
// - counters wrap after 65535 and reads do not clear them
// - count all, unicast, multicast and broadcast received frames
// - count all, unicast, multicast and broadcast transmitted frames
// - count crc, alignment, phy, length and gap receive errors
// - count queue-full drops and filter drops per port
// - store only with 256 bytes free and whole frame fitting, else full drop
//
// Decided for this implementation: the register addresses and register access over APB.
module swf_forward
    import swf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire swf_rx_frame_t [NUM_PORTS-1:0] rx_frame,
    input wire swf_tx_event_t [NUM_PORTS-1:0] tx_event,
    input wire swf_release_t [NUM_PORTS-1:0] q_release,
    output swf_fwd_t [NUM_PORTS-1:0] fwd_out
);

    // ======================================================
    // state
    typedef struct packed {
        logic [NUM_FILT-1:0][31:0] filt_hi;
        logic [NUM_FILT-1:0][31:0] filt_lo;
        logic [NUM_MASKED-1:0][31:0] mask_hi;
        logic [NUM_MASKED-1:0][31:0] mask_lo;
        logic [31:0] cfg;
        logic [31:0] qsize;
        logic [NUM_PORTS-1:0][1:0][QW-1:0] occ;
        swf_fwd_t [NUM_PORTS-1:0] fwd;
        logic [31:0] prdata;
        logic perr;
    } swf_fwd_state_t;

    localparam swf_fwd_state_t ST_RST = '{
        filt_hi: {NUM_FILT{FILT_RST}},
        filt_lo: {NUM_FILT{FILT_RST}},
        mask_hi: {NUM_MASKED{MASK_HI_RST}},
        mask_lo: {NUM_MASKED{MASK_LO_RST}},
        cfg: CFG_RST,
        qsize: QSIZE_RST,
        occ: '0,
        fwd: '0,
        prdata: '0,
        perr: 1'b0
    };

    swf_fwd_state_t st_r;
    swf_fwd_state_t st_nxt;

    logic [IDX_W-1:0] idx;
    logic [NUM_PORTS-1:0][NUM_STATS-1:0] stat_inc;
    logic [NUM_PORTS-1:0][STAT_W-1:0] stat_rd;
    logic [NUM_PORTS-1:0] err_m;
    logic [NUM_PORTS-1:0] hit_m;
    logic [NUM_PORTS-1:0] unk_m;
    logic [NUM_PORTS-1:0] want_m;
    logic [NUM_PORTS-1:0] host_m;
    logic [NUM_PORTS-1:0] other_m;
    logic [NUM_PORTS-1:0] room_m;
    logic [NUM_PORTS-1:0] admit_m;
    logic [NUM_PORTS-1:0][QW-1:0] free_m;

    assign idx = paddr[IDX_W+1:2];

    // ======================================================
    // next state
    always_comb
    begin
        logic [47:0] fa;
        logic [47:0] fm;
        logic apply;
        logic unk_other;
        logic unk_host;
        logic hit_host;
        logic hit_other;
        logic q;
        logic [QW-1:0] limit;
        logic [QW-1:0] cur;
        logic [QW-1:0] rel;
        logic [QW-1:0] flen;
        logic [4:0] fe;
        fa = '0;
        fm = '0;
        apply = 1'b0;
        unk_other = 1'b0;
        unk_host = 1'b0;
        hit_host = 1'b0;
        hit_other = 1'b0;
        q = 1'b0;
        limit = '0;
        cur = '0;
        rel = '0;
        flen = '0;
        fe = '0;
        st_nxt = st_r;
        stat_inc = '0;
        err_m = '0;
        hit_m = '0;
        unk_m = '0;
        want_m = '0;
        host_m = '0;
        other_m = '0;
        room_m = '0;
        admit_m = '0;
        free_m = '0;

        // register writes
        if (psel && penable && pwrite)
        begin
            if (idx >= IDX_FILT_FIRST && idx <= IDX_FILT_LAST)
            begin
                fe = 5'(idx - IDX_FILT_FIRST);
                if (!fe[0])
                begin
                    st_nxt.filt_hi[fe[4:1]] = pwdata & FILT_HI_WMASK;
                end
                else
                begin
                    st_nxt.filt_lo[fe[4:1]] = pwdata;
                end
            end
            else if (idx >= IDX_MASK_FIRST && idx <= IDX_MASK_LAST)
            begin
                fe = 5'(idx - IDX_MASK_FIRST);
                if (!fe[0])
                begin
                    st_nxt.mask_hi[fe[1]] = pwdata & MASK_HI_WMASK;
                end
                else
                begin
                    st_nxt.mask_lo[fe[1]] = pwdata;
                end
            end
            else if (idx == IDX_CFG)
            begin
                st_nxt.cfg = pwdata;
            end
            else if (idx == IDX_QSIZE)
            begin
                st_nxt.qsize = pwdata;
            end
        end

        // register reads, captured in the setup cycle
        if (psel && !penable)
        begin
            st_nxt.prdata = '0;
            st_nxt.perr = 1'b0;
            if (idx >= IDX_FILT_FIRST && idx <= IDX_FILT_LAST)
            begin
                fe = 5'(idx - IDX_FILT_FIRST);
                st_nxt.prdata = fe[0] ? st_r.filt_lo[fe[4:1]] : st_r.filt_hi[fe[4:1]];
            end
            else if (idx >= IDX_MASK_FIRST && idx <= IDX_MASK_LAST)
            begin
                fe = 5'(idx - IDX_MASK_FIRST);
                st_nxt.prdata = fe[0] ? st_r.mask_lo[fe[1]] : st_r.mask_hi[fe[1]];
            end
            else if (idx == IDX_CFG)
            begin
                st_nxt.prdata = st_r.cfg;
            end
            else if (idx == IDX_QSIZE)
            begin
                st_nxt.prdata = st_r.qsize;
            end
            else if (idx >= IDX_STAT_P1 && idx < IDX_STAT_P1 + IDX_W'(NUM_STATS))
            begin
                st_nxt.prdata = 32'(stat_rd[0]);
            end
            else if (idx >= IDX_STAT_P2 && idx < IDX_STAT_P2 + IDX_W'(NUM_STATS))
            begin
                st_nxt.prdata = 32'(stat_rd[1]);
            end
            else
            begin
                st_nxt.perr = 1'b1;
            end
        end

        // per-port forwarding decision and queue accounting
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            hit_host = 1'b0;
            hit_other = 1'b0;
            for (int i = 0; i < NUM_FILT; i++)
            begin
                fa = {st_r.filt_hi[i][15:0], st_r.filt_lo[i]};
                fm = 48'hFFFFFFFFFFFF;
                if (i < NUM_MASKED)
                begin
                    fm = {st_r.mask_hi[i[0]][15:0], st_r.mask_lo[i[0]]};
                end
                apply = (p == 0) ? st_r.filt_hi[i][FH_APPLY1] : st_r.filt_hi[i][FH_APPLY2];
                if (apply && ((rx_frame[p].da ^ fa) & fm) == '0)
                begin
                    hit_m[p] = 1'b1;
                    hit_host = hit_host | st_r.filt_hi[i][FH_HOST];
                    hit_other = hit_other | st_r.filt_hi[i][FH_OTHER];
                end
            end
            unk_other = (p == 0) ? st_r.cfg[CFG_UNK_P1_P2] : st_r.cfg[CFG_UNK_P2_P1];
            unk_host = (p == 0) ? st_r.cfg[CFG_UNK_P1_HOST] : st_r.cfg[CFG_UNK_P2_HOST];
            unk_m[p] = unk_other | unk_host;
            err_m[p] = rx_frame[p].crc_err | rx_frame[p].align_err
                | rx_frame[p].phy_err | rx_frame[p].len_err;
            host_m[p] = hit_m[p] ? hit_host : unk_host;
            other_m[p] = hit_m[p] ? hit_other : unk_other;
            want_m[p] = !err_m[p] && (host_m[p] || other_m[p]);

            // queue release first, then admission on the freed space
            for (int k = 0; k < 2; k++)
            begin
                cur = st_r.occ[p][k];
                rel = QW'(q_release[p].bytes);
                if (q_release[p].valid && q_release[p].hi == k[0])
                begin
                    st_nxt.occ[p][k] = (rel > cur) ? '0 : cur - rel;
                end
            end
            q = rx_frame[p].hi_prio;
            limit = QW'(st_r.qsize[(p * 2 + int'(q)) * QSZ_FLD_W +: QSZ_FLD_W]) << KB_SHIFT;
            cur = st_nxt.occ[p][q];
            free_m[p] = (cur >= limit) ? '0 : limit - cur;
            flen = QW'(rx_frame[p].len);
            room_m[p] = (free_m[p] >= ROOM_MIN) && (flen <= free_m[p]);
            admit_m[p] = rx_frame[p].valid && want_m[p] && room_m[p];
            st_nxt.fwd[p].valid = admit_m[p];
            st_nxt.fwd[p].deliver_flag_a = admit_m[p] && host_m[p];
            st_nxt.fwd[p].to_other = admit_m[p] && other_m[p];
            st_nxt.fwd[p].hi_prio = q;
            st_nxt.fwd[p].len = rx_frame[p].len;
            if (admit_m[p])
            begin
                st_nxt.occ[p][q] = cur + flen;
            end

            // receive statistics
            if (rx_frame[p].valid)
            begin
                stat_inc[p][ST_RX_FRM] = 1'b1;
                stat_inc[p][ST_RX_BC] = rx_frame[p].da == DA_BCAST;
                stat_inc[p][ST_RX_MC] = rx_frame[p].da[DA_GROUP_BIT]
                    && rx_frame[p].da != DA_BCAST;
                stat_inc[p][ST_RX_UC] = !rx_frame[p].da[DA_GROUP_BIT];
                stat_inc[p][ST_RX_CRC] = rx_frame[p].crc_err;
                stat_inc[p][ST_RX_ALGN] = rx_frame[p].align_err;
                stat_inc[p][ST_RX_PHY] = rx_frame[p].phy_err;
                stat_inc[p][ST_RX_LEN] = rx_frame[p].len_err;
                stat_inc[p][ST_RX_IFG] = rx_frame[p].ifg_err;
                stat_inc[p][ST_DROP_FILT] = !err_m[p] && !want_m[p];
                stat_inc[p][ST_DROP_FULL] = want_m[p] && !room_m[p];
            end

            // transmit statistics
            if (tx_event[p].valid)
            begin
                stat_inc[p][ST_TX_FRM] = 1'b1;
                stat_inc[p][ST_TX_BC] = tx_event[p].da == DA_BCAST;
                stat_inc[p][ST_TX_MC] = tx_event[p].da[DA_GROUP_BIT]
                    && tx_event[p].da != DA_BCAST;
                stat_inc[p][ST_TX_UC] = !tx_event[p].da[DA_GROUP_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ======================================================
    // counters
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_stat
        swf_stat_bank #(.NUM(NUM_STATS), .W(STAT_W)) u_bank (
            .pclk(pclk),
            .presetn(presetn),
            .inc(stat_inc[p]),
            .rd_sel(idx[3:0]),
            .rd_data(stat_rd[p])
        );
    end

    // ======================================================
    // outputs
    assign prdata = st_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && st_r.perr;
    assign fwd_out = st_r.fwd;

    // ======================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_err_drop;
        (rx_frame[0].valid && err_m[0]) |=> !fwd_out[0].valid;
    endproperty
    a_err_drop: assert property (p_err_drop) else $error("errored frame forwarded");
    property p_unknown_drop;
        (rx_frame[1].valid && !hit_m[1] && !unk_m[1]) |=> !fwd_out[1].valid;
    endproperty
    a_unknown_drop: assert property (p_unknown_drop) else $error("unknown frame forwarded");
    property p_cause;
        fwd_out[0].valid |-> $past(hit_m[0] || unk_m[0]);
    endproperty
    a_cause: assert property (p_cause) else $error("forward without match or option");
    property p_room;
        fwd_out[0].valid |-> $past(free_m[0] >= ROOM_MIN);
    endproperty
    a_room: assert property (p_room) else $error("frame stored without room");
    property p_host;
        (admit_m[0] && hit_m[0] && host_m[0]) |=> fwd_out[0].deliver_flag_a;
    endproperty
    a_host: assert property (p_host) else $error("host flag ignored");
    property p_both;
        (admit_m[1] && host_m[1] && other_m[1]) |=> fwd_out[1].deliver_flag_a && fwd_out[1].to_other;
    endproperty
    a_both: assert property (p_both) else $error("dual destination lost");
    property p_filt_cnt;
        (rx_frame[0].valid && !err_m[0] && !hit_m[0] && !unk_m[0])
            |-> stat_inc[0][ST_DROP_FILT] && !stat_inc[0][ST_DROP_FULL];
    endproperty
    a_filt_cnt: assert property (p_filt_cnt) else $error("filter drop not counted once");
    property p_full_cnt;
        (rx_frame[1].valid && want_m[1] && free_m[1] < ROOM_MIN) |-> stat_inc[1][ST_DROP_FULL];
    endproperty
    a_full_cnt: assert property (p_full_cnt) else $error("full drop not counted");

    c_both: cover property (fwd_out[0].deliver_flag_a && fwd_out[0].to_other);
    c_full: cover property (stat_inc[1][ST_DROP_FULL]);
    c_unknown: cover property (fwd_out[1].valid && $past(!hit_m[1]));

endmodule

// file: swf_pkg.sv
// shared constants and carriers of the receive forwarding filter
// assumes one pclk domain and an apb master on the register side
package swf_pkg;

    // ======================================================
    // sizes
    localparam int NUM_PORTS = 2;
    localparam int NUM_FILT = 16;
    localparam int NUM_MASKED = 2;
    localparam int NUM_STATS = 15;
    localparam int STAT_W = 16;
    localparam int LEN_W = 14;
    localparam int QW = 18;
    localparam int IDX_W = 8;
    localparam int QSZ_FLD_W = 8;
    localparam int KB_SHIFT = 10;

    // ======================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CFG = 8'h06;
    localparam logic [IDX_W-1:0] IDX_FILT_FIRST = 8'h50;
    localparam logic [IDX_W-1:0] IDX_FILT_LAST = 8'h6F;
    localparam logic [IDX_W-1:0] IDX_MASK_FIRST = 8'h70;
    localparam logic [IDX_W-1:0] IDX_MASK_LAST = 8'h73;
    localparam logic [IDX_W-1:0] IDX_QSIZE = 8'h78;
    localparam logic [IDX_W-1:0] IDX_STAT_P1 = 8'h80;
    localparam logic [IDX_W-1:0] IDX_STAT_P2 = 8'h90;

    // ======================================================
    // reset values and field layout
    localparam logic [31:0] CFG_RST = 32'h00000800;
    localparam int CFG_UNK_P2_P1 = 4;
    localparam int CFG_UNK_P1_P2 = 5;
    localparam int CFG_UNK_P2_HOST = 6;
    localparam int CFG_UNK_P1_HOST = 7;
    localparam logic [31:0] QSIZE_RST = 32'h080C080C;
    localparam logic [31:0] FILT_RST = 32'h00000000;
    localparam logic [31:0] FILT_HI_WMASK = 32'hC003FFFF;
    localparam int FH_HOST = 16;
    localparam int FH_OTHER = 17;
    localparam int FH_APPLY1 = 30;
    localparam int FH_APPLY2 = 31;
    localparam logic [31:0] MASK_HI_RST = 32'h0000FFFF;
    localparam logic [31:0] MASK_LO_RST = 32'hFFFFFFFF;
    localparam logic [31:0] MASK_HI_WMASK = 32'h0000FFFF;
    localparam logic [QW-1:0] ROOM_MIN = 18'h00100;
    localparam logic [47:0] DA_BCAST = 48'hFFFFFFFFFFFF;
    localparam int DA_GROUP_BIT = 40;

    // ======================================================
    // statistics counter slots
    localparam int ST_RX_FRM = 0;
    localparam int ST_RX_UC = 1;
    localparam int ST_RX_MC = 2;
    localparam int ST_RX_BC = 3;
    localparam int ST_RX_CRC = 4;
    localparam int ST_RX_ALGN = 5;
    localparam int ST_RX_PHY = 6;
    localparam int ST_RX_LEN = 7;
    localparam int ST_TX_FRM = 8;
    localparam int ST_TX_UC = 9;
    localparam int ST_TX_MC = 10;
    localparam int ST_TX_BC = 11;
    localparam int ST_DROP_FULL = 12;
    localparam int ST_DROP_FILT = 13;
    localparam int ST_RX_IFG = 14;

    // ======================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [47:0] da;
        logic [LEN_W-1:0] len;
        logic hi_prio;
        logic crc_err;
        logic align_err;
        logic phy_err;
        logic len_err;
        logic ifg_err;
    } swf_rx_frame_t;

    typedef struct packed {
        logic valid;
        logic [47:0] da;
    } swf_tx_event_t;

    typedef struct packed {
        logic valid;
        logic hi;
        logic [LEN_W-1:0] bytes;
    } swf_release_t;

    typedef struct packed {
        logic valid;
        logic to_other;
        logic deliver_flag_a;
        logic hi_prio;
        logic [LEN_W-1:0] len;
    } swf_fwd_t;

endpackage

// file: swf_stat_bank.sv
// bank of wrapping statistics counters for one port
// assumes increment strobes are one-cycle pulses on pclk
module swf_stat_bank
    import swf_pkg::*;
#(
    parameter int NUM = NUM_STATS,
    parameter int W = STAT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM-1:0] inc,
    input wire logic [3:0] rd_sel,
    output logic [W-1:0] rd_data
);

    // ======================================================
    // state
    typedef struct packed {
        logic [NUM-1:0][W-1:0] cnt;
    } swf_stat_state_t;

    swf_stat_state_t st_r;
    swf_stat_state_t st_nxt;

    if (NUM < 1 || NUM > 16 || W < 1)
    begin : g_bad_size
        $error("swf_stat_bank: unsupported size");
    end

    // ======================================================
    // counting, reads leave counters untouched
    always_comb
    begin
        st_nxt = st_r;
        for (int i = 0; i < NUM; i++)
        begin
            if (inc[i])
            begin
                st_nxt.cnt[i] = st_r.cnt[i] + W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_comb
    begin
        rd_data = '0;
        if (int'(rd_sel) < NUM)
        begin
            rd_data = st_r.cnt[rd_sel];
        end
    end

    // ======================================================
    // checks
    for (genvar g = 0; g < NUM; g++)
    begin : g_chk
        property p_wrap;
            @(posedge pclk) disable iff (!presetn)
            (inc[g] && st_r.cnt[g] == {W{1'b1}}) |=> st_r.cnt[g] == '0;
        endproperty
        a_wrap: assert property (p_wrap) else $error("counter did not wrap");
        property p_hold;
            @(posedge pclk) disable iff (!presetn)
            !inc[g] |=> $stable(st_r.cnt[g]);
        endproperty
        a_hold: assert property (p_hold) else $error("counter moved without event");
        property p_step;
            @(posedge pclk) disable iff (!presetn)
            inc[g] |=> st_r.cnt[g] == W'($past(st_r.cnt[g]) + 1);
        endproperty
        a_step: assert property (p_step) else $error("counter did not step by one");
    end

endmodule

// file: swf_phy_model.sv
// far side model: two phy receive ports handing frame descriptors
// assumes the bench calls send for one port at a time
module swf_phy_model
    import swf_pkg::*;
(
    input wire logic pclk,
    output swf_rx_frame_t [NUM_PORTS-1:0] rx_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================
    // one-cycle frame pulse, da scrambled between frames
    initial rx_frame = '0;
    task automatic send(input logic p, input logic [47:0] da, input logic [LEN_W-1:0] len,
        input logic crc);
        @(posedge pclk);
        rx_frame[p] <= '{valid: 1'b1, da: da, len: len, crc_err: crc, default: '0};
        @(posedge pclk);
        rx_frame[p].valid <= 1'b0;
        rx_frame[p].da <= ~da;
    endtask
endmodule

// file: testbench.sv
// self-checking bench of the receive forwarding filter
// assumes zero wait state apb and one frame pulse per call
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import swf_pkg::*;
    `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
        $display("wrong value at %0t: %h %h", $time, a, b); end end
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    swf_rx_frame_t [NUM_PORTS-1:0] rx_frame;
    swf_tx_event_t [NUM_PORTS-1:0] tx_event = '0;
    swf_release_t [NUM_PORTS-1:0] q_release = '0;
    swf_fwd_t [NUM_PORTS-1:0] fwd_out;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_rx[2] = '{0, 0};
    int n_filt[2] = '{0, 0};
    int n_crc[2] = '{0, 0};
    logic [15:0] r = 16'h0060;
    logic [31:0] rd;
    logic er;
    logic [47:0] da0 = 48'h08000012AB00;
    logic [47:0] da1 = 48'h0A11223344EE;
    // ======================================================
    // clock, timeout, instances
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 5000) begin errors++; stop_test(); end
    swf_forward i_swf_forward (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame),
        .tx_event(tx_event), .q_release(q_release), .fwd_out(fwd_out));
    swf_phy_model i_swf_phy_model (.pclk(pclk), .rx_frame(rx_frame));
    // ======================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [1:0] unk_route(input int b, input int p);
        return (p == ((b == 4 || b == 6) ? 1 : 0)) ? (b < 6 ? 2'b10 : 2'b01) : 2'b00;
    endfunction
    function automatic logic [47:0] rnd_da();
        r = lfsr(r);
        return {8'h02, r, 8'h5C, r ^ 16'h3A5A};
    endfunction
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input int p, input logic [47:0] da, input logic crc,
        input logic [1:0] ex);
        r = lfsr(r);
        i_swf_phy_model.send(p[0], da, LEN_W'(64 + r[7:0]), crc);
        #1;
        `CHK(fwd_out[p].valid, |ex)
        if (|ex) `CHK({fwd_out[p].to_other, fwd_out[p].deliver_flag_a}, ex)
        if (|ex) `CHK({fwd_out[p].hi_prio, fwd_out[p].len}, {1'b0, LEN_W'(64 + r[7:0])})
        n_rx[p]++;
        if (crc) n_crc[p]++;
        else if (ex == 2'b00) n_filt[p]++;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ======================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, IDX_CFG, 0);
        `CHK(rd, CFG_RST)
        apb(0, IDX_QSIZE, 0);
        `CHK(rd, QSIZE_RST)
        apb(0, IDX_MASK_FIRST, 0);
        `CHK(rd, MASK_HI_RST)
        apb(0, 8'h01, 0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1, IDX_QSIZE, 32'h070C080C);
        apb(0, IDX_QSIZE, 0);
        `CHK(rd, 32'h070C080C)
        frame(0, rnd_da(), 0, 2'b00);
        frame(1, rnd_da(), 0, 2'b00);
        $display("test reset done");
        apb(1, IDX_FILT_FIRST, 32'h40030000 | {16'h0, da0[47:32]});
        apb(1, IDX_FILT_FIRST + 8'h01, da0[31:0]);
        apb(1, IDX_MASK_FIRST + 8'h01, 32'hFFFFFF00);
        apb(1, IDX_FILT_LAST - 8'h01, 32'h80010000 | {16'h0, da1[47:32]});
        apb(1, IDX_FILT_LAST, da1[31:0]);
        frame(0, da0 | 48'h5D, 0, 2'b11);
        frame(0, da0 ^ 48'h100, 0, 2'b00);
        frame(1, da0, 0, 2'b00);
        frame(1, da1, 0, 2'b01);
        frame(0, da1, 0, 2'b00);
        frame(0, da0, 1, 2'b00);
        $display("test filter done");
        for (int b = 4; b < 8; b++)
        begin
            apb(1, IDX_CFG, CFG_RST | (32'h1 << b));
            for (int p = 0; p < 2; p++) frame(p, rnd_da(), 0, unk_route(b, p));
        end
        // empty port 2 low queue, nearly fill it, then overflow it
        apb(1, IDX_CFG, CFG_RST | (32'h1 << CFG_UNK_P2_HOST));
        @(posedge pclk);
        q_release[1] <= '{valid: 1'b1, hi: 1'b0, bytes: '1};
        @(posedge pclk);
        q_release[1] <= '0;
        i_swf_phy_model.send(1'b1, rnd_da(), 14'h2F80, 1'b0);
        #1;
        `CHK({fwd_out[1].valid, fwd_out[1].deliver_flag_a}, 2'b11)
        i_swf_phy_model.send(1'b1, rnd_da(), 14'h0040, 1'b0);
        #1;
        `CHK(fwd_out[1].valid, 1'b0)
        n_rx[1] += 2;
        @(posedge pclk);
        tx_event[1] <= '{valid: 1'b1, da: DA_BCAST};
        @(posedge pclk);
        tx_event[1] <= '0;
        apb(1, IDX_CFG, CFG_RST);
        frame(1, rnd_da(), 1, 2'b00);
        $display("test unknown done");
        // host reads frame, filter drop and crc counters of both ports and three port 2 counters well inside the wrap interval
        for (int p = 0; p < 2; p++)
        begin
            repeat (2)
            begin
                apb(0, IDX_STAT_P1 + 8'(16 * p + ST_RX_FRM), 0);
                `CHK(rd, 32'(n_rx[p]))
            end
            apb(0, IDX_STAT_P1 + 8'(16 * p + ST_DROP_FILT), 0);
            `CHK(rd, 32'(n_filt[p]))
            apb(0, IDX_STAT_P1 + 8'(16 * p + ST_RX_CRC), 0);
            `CHK(rd, 32'(n_crc[p]))
        end
        apb(0, IDX_STAT_P2 + 8'(ST_DROP_FULL), 0);
        `CHK(rd, 32'h1)
        apb(0, IDX_STAT_P2 + 8'(ST_TX_BC), 0);
        `CHK(rd, 32'h1)
        apb(0, IDX_STAT_P2 + 8'(ST_TX_FRM), 0);
        `CHK(rd, 32'h1)
        $display("test counters done");
        stop_test();
    end
endmodule
